// ### verilog/rcr_pkg.sv
// Purpose: constants for the regulator control register bank
// Assumes: 8-bit register offsets, one byte per register
// Notes: rail index 0 = stepdown5, 1 = stepdown6, 2 = linear2
package rcr_pkg;
	// ==========================================================
	// rails and register map
	localparam int RCR_NUM_RAILS = 3;
	localparam int RCR_RAIL_STEPDOWN5 = 0;
	localparam int RCR_RAIL_STEPDOWN6 = 1;
	localparam int RCR_RAIL_LINEAR2 = 2;
	localparam logic [7:0] RCR_OFS_STEPDOWN5_CONTROL = 8'h26;
	localparam logic [7:0] RCR_OFS_STEPDOWN6_CONTROL = 8'h27;
	localparam logic [7:0] RCR_OFS_LINEAR_REG2_CONTROL = 8'h28;
	localparam logic [2:0][7:0] RCR_RAIL_OFS = {RCR_OFS_LINEAR_REG2_CONTROL, RCR_OFS_STEPDOWN6_CONTROL,
		RCR_OFS_STEPDOWN5_CONTROL};
	// ==========================================================
	// reset values and writable bits
	localparam logic [7:0] RCR_RST_STEPDOWN = 8'h0C;
	localparam logic [7:0] RCR_RST_LINEAR = 8'h0C;
	localparam logic [2:0][7:0] RCR_RAIL_RST = {RCR_RST_LINEAR, RCR_RST_STEPDOWN, RCR_RST_STEPDOWN};
	localparam logic [7:0] RCR_WR_MASK = 8'h3F;
	// both sleep pins read as not asleep until the synchroniser has real samples
	localparam logic [1:0] RCR_SLEEP_PIN_IDLE = 2'h3;
	// ==========================================================
	// field positions and encodings
	localparam int RCR_SLEEP_SEL_HI = 5;
	localparam int RCR_SLEEP_SEL_LO = 4;
	localparam int RCR_MODE_BIT = 1;
	localparam int RCR_DISABLE_BIT = 0;
	localparam logic [1:0] RCR_SLEEP_SEL_NORMAL = 2'h0;
	localparam logic [1:0] RCR_SLEEP_SEL_ACTIVE = 2'h3;
endpackage : rcr_pkg

// ### verilog/rcr_regulator_control_regs.sv
// Purpose: control registers for stepdown5, stepdown6 and linear2 rails
// Assumes: register strobes come from the serial slave on I_REF_CLK
// Notes: sleep pins are asynchronous and are synchronised here
`timescale 1ns/1ps
`default_nettype none

module rcr_regulator_control_regs (
	input wire logic I_REF_CLK,
	input wire logic I_RST_N,
	input wire logic I_REG_WR_EN,
	input wire logic I_REG_RD_EN,
	input wire logic [7:0] I_REG_ADDR,
	input wire logic [7:0] I_REG_WDATA,
	output logic [7:0] O_REG_RDATA,
	output logic O_REG_HIT,
	input wire logic I_FIRST_SLEEP_PIN,
	input wire logic I_SECOND_SLEEP_PIN,
	input wire logic [2:0] I_SLEEP_PIN_ASSIGN,
	input wire logic [2:0] I_RAIL_ON_REQ,
	output logic [2:0] O_RAIL_ENABLE,
	output logic [2:0] O_RAIL_USE_SLEEP_CODE,
	output logic O_STEPDOWN5_FORCED_PWM,
	output logic O_STEPDOWN6_FORCED_PWM
);

	// ==========================================================
	// sleep pin synchronisers
	logic [1:0] sleep_meta_ff;
	logic [1:0] sleep_sync_ff;

	always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			sleep_meta_ff <= rcr_pkg::RCR_SLEEP_PIN_IDLE;
			sleep_sync_ff <= rcr_pkg::RCR_SLEEP_PIN_IDLE;
		end else begin
			sleep_meta_ff <= {I_SECOND_SLEEP_PIN, I_FIRST_SLEEP_PIN};
			sleep_sync_ff <= sleep_meta_ff;
		end
	end

	// ==========================================================
	// control registers and rail outputs
	logic [7:0] ctrl_ff [rcr_pkg::RCR_NUM_RAILS];
	logic [2:0] enable_ff;
	logic [2:0] use_sleep_ff;
	logic [2:0] nxt_enable;
	logic [2:0] nxt_use_sleep;
	logic [2:0] assigned_pin;

	for (genvar g = 0; g < rcr_pkg::RCR_NUM_RAILS; g++) begin : g_rail
		always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
			if (!I_RST_N) begin
				ctrl_ff[g] <= rcr_pkg::RCR_RAIL_RST[g];
			end else if (I_REG_WR_EN && I_REG_ADDR == rcr_pkg::RCR_RAIL_OFS[g]) begin
				ctrl_ff[g] <= I_REG_WDATA & rcr_pkg::RCR_WR_MASK;
			end
		end

		// pin choice is a factory strap, deliberately absent from the register
		assign assigned_pin[g] = I_SLEEP_PIN_ASSIGN[g] ? sleep_sync_ff[1] : sleep_sync_ff[0];
		// reserved 01/10 fall back to normal code rather than a guess
		assign nxt_use_sleep[g] = (ctrl_ff[g][rcr_pkg::RCR_SLEEP_SEL_HI:rcr_pkg::RCR_SLEEP_SEL_LO]
			== rcr_pkg::RCR_SLEEP_SEL_ACTIVE) && !assigned_pin[g];
		assign nxt_enable[g] = ctrl_ff[g][rcr_pkg::RCR_DISABLE_BIT] && I_RAIL_ON_REQ[g];
	end

	always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			enable_ff <= 3'h0;
			use_sleep_ff <= 3'h0;
		end else begin
			enable_ff <= nxt_enable;
			use_sleep_ff <= nxt_use_sleep;
		end
	end

	assign O_RAIL_ENABLE = enable_ff;
	assign O_RAIL_USE_SLEEP_CODE = use_sleep_ff;
	assign O_STEPDOWN5_FORCED_PWM = ctrl_ff[rcr_pkg::RCR_RAIL_STEPDOWN5][rcr_pkg::RCR_MODE_BIT];
	assign O_STEPDOWN6_FORCED_PWM = ctrl_ff[rcr_pkg::RCR_RAIL_STEPDOWN6][rcr_pkg::RCR_MODE_BIT];

	// ==========================================================
	// read path
	logic [7:0] rdata_ff;
	logic hit_ff;
	logic [7:0] nxt_rdata;
	logic nxt_hit;

	always_comb begin
		nxt_rdata = 8'h00;
		nxt_hit = 1'b0;
		for (int r = 0; r < rcr_pkg::RCR_NUM_RAILS; r++) begin
			if (I_REG_ADDR == rcr_pkg::RCR_RAIL_OFS[r]) begin
				nxt_rdata = ctrl_ff[r];
				nxt_hit = 1'b1;
			end
		end
	end

	always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			rdata_ff <= 8'h00;
			hit_ff <= 1'b0;
		end else if (I_REG_RD_EN) begin
			rdata_ff <= nxt_rdata;
			hit_ff <= nxt_hit;
		end
	end

	assign O_REG_RDATA = rdata_ff;
	assign O_REG_HIT = hit_ff;

	// ==========================================================
	// assertions
	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RST_N);

	logic [1:0] sel5;
	logic [1:0] sel6;
	logic [1:0] sel2;
	assign sel5 = ctrl_ff[0][rcr_pkg::RCR_SLEEP_SEL_HI:rcr_pkg::RCR_SLEEP_SEL_LO];
	assign sel6 = ctrl_ff[1][rcr_pkg::RCR_SLEEP_SEL_HI:rcr_pkg::RCR_SLEEP_SEL_LO];
	assign sel2 = ctrl_ff[2][rcr_pkg::RCR_SLEEP_SEL_HI:rcr_pkg::RCR_SLEEP_SEL_LO];

	a_s5_normal_only: assert property (sel5 == 2'h0 |=> !O_RAIL_USE_SLEEP_CODE[0])
		else $error("stepdown5 used sleep code with select 00");
	a_s5_sleep_follow: assert property (sel5 == 2'h3 && !assigned_pin[0]
		|=> O_RAIL_USE_SLEEP_CODE[0])
		else $error("stepdown5 missed sleep code with pin low");
	a_s6_sleep_map: assert property (##1 O_RAIL_USE_SLEEP_CODE[1]
		== ($past(sel6) == 2'h3 && !$past(assigned_pin[1])))
		else $error("stepdown6 sleep code selection wrong");
	a_l2_sleep_map: assert property (##1 O_RAIL_USE_SLEEP_CODE[2]
		== ($past(sel2) == 2'h3 && !$past(assigned_pin[2])))
		else $error("linear2 sleep code selection wrong");
	// same-cycle check: the synchronised pin may legally move on the next edge
	a_pin_fixed_route: assert property ($stable(I_SLEEP_PIN_ASSIGN) && $stable(sleep_sync_ff)
		&& I_REG_WR_EN |-> $stable(assigned_pin))
		else $error("register write moved sleep pin routing");
	a_s6_mode_write: assert property (I_REG_WR_EN && I_REG_ADDR == 8'h27
		|=> O_STEPDOWN6_FORCED_PWM == $past(I_REG_WDATA[1]))
		else $error("stepdown6 mode did not follow write");
	a_s5_off_forced: assert property (!ctrl_ff[0][0] |=> !O_RAIL_ENABLE[0])
		else $error("stepdown5 on while disabled");
	a_s6_off_forced: assert property (!ctrl_ff[1][0] |=> !O_RAIL_ENABLE[1])
		else $error("stepdown6 on while disabled");
	a_l2_off_forced: assert property (!ctrl_ff[2][0] |=> !O_RAIL_ENABLE[2])
		else $error("linear2 on while disabled");
	a_enable_and: assert property (ctrl_ff[2][0] && I_RAIL_ON_REQ[2] ##1 ctrl_ff[2][0] && I_RAIL_ON_REQ[2]
		|=> O_RAIL_ENABLE[2] [*1])
		else $error("linear2 not on with request and enable");
	a_upper_zero: assert property (I_REG_RD_EN |=> O_REG_RDATA[7:6] == 2'h0)
		else $error("reserved upper bits read nonzero");

	// ==========================================================
	// register storage checks
	logic wr5;
	logic wr6;
	logic wr2;
	assign wr5 = I_REG_WR_EN && I_REG_ADDR == rcr_pkg::RCR_OFS_STEPDOWN5_CONTROL;
	assign wr6 = I_REG_WR_EN && I_REG_ADDR == rcr_pkg::RCR_OFS_STEPDOWN6_CONTROL;
	assign wr2 = I_REG_WR_EN && I_REG_ADDR == rcr_pkg::RCR_OFS_LINEAR_REG2_CONTROL;

	a_s5_write_lands: assert property (wr5
		|=> ctrl_ff[0] == ($past(I_REG_WDATA) & rcr_pkg::RCR_WR_MASK))
		else $error("stepdown5 write did not land");
	a_s6_write_lands: assert property (wr6
		|=> ctrl_ff[1] == ($past(I_REG_WDATA) & rcr_pkg::RCR_WR_MASK))
		else $error("stepdown6 write did not land");
	a_l2_write_lands: assert property (wr2
		|=> ctrl_ff[2] == ($past(I_REG_WDATA) & rcr_pkg::RCR_WR_MASK))
		else $error("linear2 write did not land");
	a_s5_hold_idle: assert property (!wr5
		|=> $stable(ctrl_ff[0]))
		else $error("stepdown5 register changed without write");
	a_s6_hold_idle: assert property (!wr6
		|=> $stable(ctrl_ff[1]))
		else $error("stepdown6 register changed without write");
	a_l2_hold_idle: assert property (!wr2
		|=> $stable(ctrl_ff[2]))
		else $error("linear2 register changed without write");
	a_s5_select_write: assert property (wr5
		|=> sel5 == $past(I_REG_WDATA[5:4]))
		else $error("stepdown5 select did not follow write");
	a_s6_select_write: assert property (wr6
		|=> sel6 == $past(I_REG_WDATA[5:4]))
		else $error("stepdown6 select did not follow write");
	a_l2_select_write: assert property (wr2
		|=> sel2 == $past(I_REG_WDATA[5:4]))
		else $error("linear2 select did not follow write");
	a_s5_reserved_write: assert property (wr5
		|=> ctrl_ff[0][3:2] == $past(I_REG_WDATA[3:2]))
		else $error("stepdown5 reserved bits not stored");
	a_s6_reserved_write: assert property (wr6
		|=> ctrl_ff[1][3:2] == $past(I_REG_WDATA[3:2]))
		else $error("stepdown6 reserved bits not stored");
	a_l2_reserved_write: assert property (wr2
		|=> ctrl_ff[2][3:1] == $past(I_REG_WDATA[3:1]))
		else $error("linear2 reserved bits not stored");
	a_s5_mode_write: assert property (wr5
		|=> O_STEPDOWN5_FORCED_PWM == $past(I_REG_WDATA[1]))
		else $error("stepdown5 mode did not follow write");
	a_s5_mode_stable: assert property (!wr5
		|=> $stable(O_STEPDOWN5_FORCED_PWM))
		else $error("stepdown5 mode moved without write");
	a_s6_mode_stable: assert property (!wr6
		|=> $stable(O_STEPDOWN6_FORCED_PWM))
		else $error("stepdown6 mode moved without write");

	// ==========================================================
	// sleep code checks
	a_s6_normal_only: assert property (sel6 == 2'h0
		|=> !O_RAIL_USE_SLEEP_CODE[1])
		else $error("stepdown6 used sleep code with select 00");
	a_l2_normal_only: assert property (sel2 == 2'h0
		|=> !O_RAIL_USE_SLEEP_CODE[2])
		else $error("linear2 used sleep code with select 00");
	a_s6_sleep_follow: assert property (sel6 == 2'h3 && !assigned_pin[1]
		|=> O_RAIL_USE_SLEEP_CODE[1])
		else $error("stepdown6 missed sleep code with pin low");
	a_l2_sleep_follow: assert property (sel2 == 2'h3 && !assigned_pin[2]
		|=> O_RAIL_USE_SLEEP_CODE[2])
		else $error("linear2 missed sleep code with pin low");
	a_s5_pin_high: assert property (assigned_pin[0]
		|=> !O_RAIL_USE_SLEEP_CODE[0])
		else $error("stepdown5 sleep code with pin high");
	a_s6_pin_high: assert property (assigned_pin[1]
		|=> !O_RAIL_USE_SLEEP_CODE[1])
		else $error("stepdown6 sleep code with pin high");
	a_l2_pin_high: assert property (assigned_pin[2]
		|=> !O_RAIL_USE_SLEEP_CODE[2])
		else $error("linear2 sleep code with pin high");
	a_sync_two_stage: assert property (1'b1
		|=> sleep_sync_ff == $past(sleep_meta_ff))
		else $error("sleep pin skipped a synchroniser stage");
	a_route_first: assert property (!I_SLEEP_PIN_ASSIGN[0]
		|-> assigned_pin[0] == sleep_sync_ff[0])
		else $error("stepdown5 not routed to first sleep pin");
	a_route_second: assert property (I_SLEEP_PIN_ASSIGN[1]
		|-> assigned_pin[1] == sleep_sync_ff[1])
		else $error("stepdown6 not routed to second sleep pin");

	// ==========================================================
	// enable checks
	a_s5_on_and: assert property (ctrl_ff[0][0] && I_RAIL_ON_REQ[0]
		|=> O_RAIL_ENABLE[0])
		else $error("stepdown5 not on with request and enable");
	a_s6_on_and: assert property (ctrl_ff[1][0] && I_RAIL_ON_REQ[1]
		|=> O_RAIL_ENABLE[1])
		else $error("stepdown6 not on with request and enable");
	a_l2_on_and: assert property (ctrl_ff[2][0] && I_RAIL_ON_REQ[2]
		|=> O_RAIL_ENABLE[2])
		else $error("linear2 not on with request and enable");
	a_s5_req_off: assert property (!I_RAIL_ON_REQ[0]
		|=> !O_RAIL_ENABLE[0])
		else $error("stepdown5 on without request");
	a_s6_req_off: assert property (!I_RAIL_ON_REQ[1]
		|=> !O_RAIL_ENABLE[1])
		else $error("stepdown6 on without request");
	a_l2_req_off: assert property (!I_RAIL_ON_REQ[2]
		|=> !O_RAIL_ENABLE[2])
		else $error("linear2 on without request");

	// ==========================================================
	// read path checks
	logic rd_mapped;
	assign rd_mapped = I_REG_ADDR == rcr_pkg::RCR_OFS_STEPDOWN5_CONTROL
		|| I_REG_ADDR == rcr_pkg::RCR_OFS_STEPDOWN6_CONTROL
		|| I_REG_ADDR == rcr_pkg::RCR_OFS_LINEAR_REG2_CONTROL;

	a_s5_read_data: assert property (I_REG_RD_EN && I_REG_ADDR == rcr_pkg::RCR_OFS_STEPDOWN5_CONTROL
		|=> O_REG_RDATA == $past(ctrl_ff[0]) && O_REG_HIT)
		else $error("stepdown5 read data wrong");
	a_s6_read_data: assert property (I_REG_RD_EN && I_REG_ADDR == rcr_pkg::RCR_OFS_STEPDOWN6_CONTROL
		|=> O_REG_RDATA == $past(ctrl_ff[1]) && O_REG_HIT)
		else $error("stepdown6 read data wrong");
	a_l2_read_data: assert property (I_REG_RD_EN && I_REG_ADDR == rcr_pkg::RCR_OFS_LINEAR_REG2_CONTROL
		|=> O_REG_RDATA == $past(ctrl_ff[2]) && O_REG_HIT)
		else $error("linear2 read data wrong");
	a_read_miss: assert property (I_REG_RD_EN && !rd_mapped
		|=> !O_REG_HIT && O_REG_RDATA == 8'h00)
		else $error("unmapped read returned data or hit");
	a_read_hold: assert property (!I_REG_RD_EN
		|=> $stable(O_REG_RDATA) && $stable(O_REG_HIT))
		else $error("read data moved without read strobe");

	c_s5_sleep_entry: cover property (sel5 == 2'h3 ##1 !assigned_pin[0] ##1 O_RAIL_USE_SLEEP_CODE[0]);
	c_l2_enable: cover property (O_RAIL_ENABLE[2] ##1 !ctrl_ff[2][0] ##1 !O_RAIL_ENABLE[2]);
	c_miss_read: cover property (I_REG_RD_EN && I_REG_ADDR == 8'h00 ##1 !O_REG_HIT);
	c_s6_auto_mode: cover property (wr6 && !I_REG_WDATA[1] ##1 !O_STEPDOWN6_FORCED_PWM);
	c_s5_turn_off: cover property (O_RAIL_ENABLE[0] ##1 !ctrl_ff[0][0] ##1 !O_RAIL_ENABLE[0]);

endmodule : rcr_regulator_control_regs

`default_nettype wire

// ### test/rcr_host_model.sv
// Purpose: host side of the register strobe port
// Assumes: one strobe per call, changed just after a rising edge
// Notes: released address and data show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module rcr_host_model (
	input wire logic i_clk,
	output logic o_wr_en,
	output logic o_rd_en,
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata,
	input wire logic [7:0] i_rdata
);
	// ==========================================================
	// bus cycles
	initial begin
		o_wr_en = 1'b0;
		o_rd_en = 1'b0;
		o_addr = 8'h00;
		o_wdata = 8'h00;
	end
	// callers keep reserved bits at 11 or 110 and stepdown5 mode at 1
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		o_wr_en <= 1'b1;
		o_addr <= a;
		o_wdata <= (d[5] ^ d[4]) ? {d[7:6], 2'h0, d[3:0]} : d; // reserved select never sent
		@(posedge i_clk);
		o_wr_en <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clk);
		o_rd_en <= 1'b1;
		o_addr <= a;
		@(posedge i_clk);
		o_rd_en <= 1'b0;
		o_addr <= ~a;
		@(negedge i_clk);
		d = i_rdata;
	endtask : rd
endmodule : rcr_host_model
`default_nettype wire

// ### test/rcr_regulator_control_regs_test.sv
// Purpose: self-checking bench for the regulator control registers
// Assumes: rail outputs settle within four edges of any change
// Notes: no waits on design handshakes, all latencies fixed
`timescale 1ns/1ps
`default_nettype none
module rcr_regulator_control_regs_test;
	logic clk, rst_n, wr, rd, p1, p2, hit, pwm5, pwm6;
	logic [7:0] addr, wdata, rdata, v;
	logic [2:0] asg, req, en, slp;
	int n_mismatch, n_compared;
	rcr_regulator_control_regs u_dut (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_REG_WR_EN(wr), .I_REG_RD_EN(rd),
		.I_REG_ADDR(addr), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .O_REG_HIT(hit), .I_FIRST_SLEEP_PIN(p1),
		.I_SECOND_SLEEP_PIN(p2), .I_SLEEP_PIN_ASSIGN(asg), .I_RAIL_ON_REQ(req), .O_RAIL_ENABLE(en),
		.O_RAIL_USE_SLEEP_CODE(slp), .O_STEPDOWN5_FORCED_PWM(pwm5), .O_STEPDOWN6_FORCED_PWM(pwm6));
	rcr_host_model u_host (.i_clk(clk), .o_wr_en(wr), .o_rd_en(rd), .o_addr(addr), .o_wdata(wdata),
		.i_rdata(rdata));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// ==========================================================
	// helpers
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wt();
		repeat (4) @(posedge clk);
		#1;
	endtask : wt
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	// ==========================================================
	// tests
	initial begin
		rst_n = 1'b0;
		p1 = 1'b1;
		p2 = 1'b1;
		asg = 3'b010;
		req = 3'b111;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		for (int r = 0; r < 3; r++) begin
			u_host.rd(8'h26 + 8'(r), v);
			chk("reset value", 8'h0C, v);
			chk("hit", 8'h01, {7'h0, hit});
		end
		u_host.rd(8'h30, v);
		chk("unmapped", 8'h00, v);
		chk("unmapped hit", 8'h00, {7'h0, hit});
		$display("test reset done");
		u_host.wr(8'h26, 8'h3F);
		u_host.wr(8'h27, 8'h3F);
		u_host.wr(8'h28, 8'h3D);
		wt();
		chk("enable", 8'h07, {5'h0, en});
		chk("pwm5", 8'h01, {7'h0, pwm5});
		chk("pwm6", 8'h01, {7'h0, pwm6});
		chk("sleep idle", 8'h00, {5'h0, slp});
		u_host.rd(8'h28, v);
		chk("linear2 readback", 8'h3D, v);
		p1 <= 1'b0;
		wt();
		chk("sleep first", 8'h05, {5'h0, slp});
		p1 <= 1'b1;
		p2 <= 1'b0;
		wt();
		chk("sleep second", 8'h02, {5'h0, slp});
		p1 <= 1'b0;
		u_host.wr(8'h26, 8'h0F);
		wt();
		chk("select normal", 8'h06, {5'h0, slp});
		$display("test sleep done");
		u_host.wr(8'h27, 8'h0D);
		wt();
		chk("pwm6 auto", 8'h00, {7'h0, pwm6});
		u_host.wr(8'h26, 8'h0E);
		u_host.wr(8'h27, 8'h0C);
		u_host.wr(8'h28, 8'h3C);
		wt();
		chk("forced off", 8'h00, {5'h0, en});
		u_host.wr(8'h26, 8'h0F);
		u_host.wr(8'h28, 8'h3D);
		req <= 3'b110;
		wt();
		chk("and of request", 8'h04, {5'h0, en});
		$display("test enable done");
		wrap_up();
	end
endmodule : rcr_regulator_control_regs_test
`default_nettype wire
